// File: rtl/fple_pkg.sv
// ---------------------------------------------------------------------------
// shared constants for the front panel indicator encoder
// ---------------------------------------------------------------------------
package fple_pkg;

  // register byte offsets
  localparam logic [11:0] OFS_CTRL      = 12'h000; // control bits
  localparam logic [11:0] OFS_BLINK     = 12'h004; // blink half period
  localparam logic [11:0] OFS_COND      = 12'h008; // status severity view
  localparam logic [11:0] OFS_LED       = 12'h00C; // led output view

  // control field positions
  localparam int CTRL_DUAL_POS = 0;   // dual-colour power led fitted
  localparam int CTRL_EN_POS   = 1;   // indicators enabled

  // reset values
  localparam logic [1:0]  CTRL_RST   = 2'h2;       // enabled, single colour
  localparam logic [23:0] BLINK_RST  = 24'h0F4240; // 1e6 cycles = 50 ms

  // power states
  typedef enum logic [1:0] {
    FPLE_PWR_OFF   = 2'b00,  // off or suspend to disk
    FPLE_PWR_ON    = 2'b01,  // running
    FPLE_PWR_SLEEP = 2'b10   // sleeping, s1
  } fple_pwr_e;

  // link speeds
  typedef enum logic [1:0] {
    FPLE_SPD_10   = 2'b00,
    FPLE_SPD_100  = 2'b01,
    FPLE_SPD_1000 = 2'b10
  } fple_spd_e;

  // status display states, most severe first
  typedef enum logic [2:0] {
    FPLE_ST_NOTRDY = 3'b000,
    FPLE_ST_CRIT   = 3'b001,
    FPLE_ST_NONCR  = 3'b010,
    FPLE_ST_DEGR   = 3'b011,
    FPLE_ST_READY  = 3'b100
  } fple_st_e;

endpackage

// File: rtl/fple_blink_if.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// blink phase carrier between the divider and the encoder
// ---------------------------------------------------------------------------
interface fple_blink_if;
  logic [23:0] half_period;  // cycles per blink half
  logic        phase;        // current blink phase
  modport ctrl (output half_period, input phase);
  modport gen  (input half_period, output phase);
endinterface

// File: rtl/fple_blink_gen.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// shared blink divider
// ---------------------------------------------------------------------------
module fple_blink_gen (
  input  wire logic   pclk,
  input  wire logic   presetn,
  fple_blink_if.gen   blk
);

  typedef struct packed {
    logic [23:0] cnt;   // cycles into current half
    logic        phase; // blink phase
  } fple_bg_s;

  fple_bg_s st;
  fple_bg_s next_st;

  // count one half period, then flip the phase; zero acts as one
  always_comb begin
    next_st = st;
    if (st.cnt + 24'h000001 >= blk.half_period) begin
      next_st.cnt   = 24'h000000;
      next_st.phase = ~st.phase;
    end else begin
      next_st.cnt = st.cnt + 24'h000001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign blk.phase = st.phase;

endmodule // fple_blink_gen

// File: rtl/fple_led_encoder.sv
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
// Operation
// - power led green on, sleep yellow/blink, off dark
// - status steady green when ready, no alarm
// - status blinks green when degraded
// - status steady amber on critical alarm
// - status blinks amber on non-critical alarm
// - status dark when system not ready
// - disk led blinks green during access
// - disk amber on fault, else dark
// - disk led merges all drive activity
// - network leds: link green, traffic blinks
// - 10/100 speed led lit at 100
// - 10/100 yellow: link on, activity blinks
// - gigabit speed: dark, green, yellow
// - gigabit green link led, activity blinks
// - identify led blinks blue when selected
// - nine front panel indicator outputs
// - power led stays alive in sleep
module fple_led_encoder #(
  parameter int NDISK = 4   // number of drive activity sources
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // condition inputs
  input  wire logic [1:0]        pwr_state,
  input  wire logic              sys_ready,
  input  wire logic              crit_alarm,
  input  wire logic              noncrit_alarm,
  input  wire logic              degraded,
  input  wire logic [NDISK-1:0]  disk_access,
  input  wire logic              disk_fault,
  input  wire logic [1:0]        net_link,
  input  wire logic [1:0]        net_act,
  input  wire logic [1:0]        net_speed_a,
  input  wire logic [1:0]        net_speed_b,
  input  wire logic              identify,
  // front panel leds
  output logic                   power_sleep_indicator_green,
  output logic                   power_sleep_indicator_yellow,
  output logic                   status_green,
  output logic                   status_amber,
  output logic                   disk_green,
  output logic                   disk_amber,
  output logic                   network_one_activity_indicator,
  output logic                   network_two_activity_indicator,
  output logic                   ident_blue,
  // jack leds
  output logic                   jack_a_speed_green,
  output logic                   jack_a_link_yellow,
  output logic                   jack_b_speed_green,
  output logic                   jack_b_speed_yellow,
  output logic                   jack_b_link_green
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [1:0]  ctrl;     // enable and dual-colour bits
    logic [23:0] half;     // blink half period in cycles
    logic [31:0] rdata;    // apb read data
    logic        rdy;      // apb ready
    logic        err;      // apb slave error
    logic [13:0] led;      // all led drives
  } fple_s;

  fple_s st;
  fple_s next_st;

  fple_blink_if blk ();

  fple_blink_gen u_blink (
    .pclk    (pclk),
    .presetn (presetn),
    .blk     (blk)
  );
  assign blk.half_period = st.half;

  // severity pick, used for display and register view
  function automatic fple_pkg::fple_st_e sev(
    input logic rdy, input logic cr, input logic nc, input logic dg);
    if (!rdy)    sev = fple_pkg::FPLE_ST_NOTRDY;
    else if (cr) sev = fple_pkg::FPLE_ST_CRIT;
    else if (nc) sev = fple_pkg::FPLE_ST_NONCR;
    else if (dg) sev = fple_pkg::FPLE_ST_DEGR;
    else         sev = fple_pkg::FPLE_ST_READY;
  endfunction

  // link led: dark without link, blink on traffic, steady otherwise
  function automatic logic link_led(
    input logic lk, input logic act, input logic ph);
    link_led = lk & (act ? ph : 1'b1);
  endfunction

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  fple_pkg::fple_st_e sv;
  logic               ph;
  logic               en;
  logic               acc;
  logic               anydisk;

  always_comb begin
    next_st = st;
    ph      = blk.phase;
    en      = st.ctrl[fple_pkg::CTRL_EN_POS];
    sv      = sev(sys_ready, crit_alarm, noncrit_alarm, degraded);
    anydisk = |disk_access;
    acc     = psel & penable;

    // apb: one wait state per access phase, ready pulse each access
    next_st.rdy = acc & ~st.rdy;
    next_st.err = 1'b0;
    if (acc & ~st.rdy) begin
      unique case (paddr)
        fple_pkg::OFS_CTRL: begin
          next_st.rdata = {30'h0, st.ctrl};
          if (pwrite) next_st.ctrl = pwdata[1:0];
        end
        fple_pkg::OFS_BLINK: begin
          next_st.rdata = {8'h00, st.half};
          if (pwrite) next_st.half = pwdata[23:0];
        end
        fple_pkg::OFS_COND: begin
          next_st.rdata = {29'h0, sv};
        end
        fple_pkg::OFS_LED: begin
          next_st.rdata = {18'h0, st.led};
        end
        default: begin
          next_st.rdata = 32'h00000000;
          next_st.err   = 1'b1;
        end
      endcase
    end

    // power led; ignores the enable so sleep stays visible
    unique case (pwr_state)
      fple_pkg::FPLE_PWR_ON:    next_st.led[1:0] = 2'b01;
      fple_pkg::FPLE_PWR_SLEEP: next_st.led[1:0] =
        st.ctrl[fple_pkg::CTRL_DUAL_POS] ? 2'b10 : {1'b0, ph};
      default:                  next_st.led[1:0] = 2'b00;
    endcase

    unique case (sv)
      fple_pkg::FPLE_ST_READY:  next_st.led[3:2] = 2'b01;
      fple_pkg::FPLE_ST_DEGR:   next_st.led[3:2] = {1'b0, ph};
      fple_pkg::FPLE_ST_CRIT:   next_st.led[3:2] = 2'b10;
      fple_pkg::FPLE_ST_NONCR:  next_st.led[3:2] = {ph, 1'b0};
      default:                  next_st.led[3:2] = 2'b00;
    endcase

    // disk; fault takes the amber, access blinks green
    next_st.led[4] = anydisk & ~disk_fault & ph;
    next_st.led[5] = disk_fault;
    next_st.led[6] = link_led(net_link[0], net_act[0], ph);
    next_st.led[7] = link_led(net_link[1], net_act[1], ph);
    next_st.led[8] = identify & ph;
    next_st.led[9]  = (net_speed_a == fple_pkg::FPLE_SPD_100);
    next_st.led[10] = link_led(net_link[0], net_act[0], ph);
    next_st.led[11] = (net_speed_b == fple_pkg::FPLE_SPD_100);
    next_st.led[12] = (net_speed_b == fple_pkg::FPLE_SPD_1000);
    next_st.led[13] = link_led(net_link[1], net_act[1], ph);

    // disabled panel blanks all but power led
    if (!en) next_st.led[13:2] = 12'h000;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st       <= '0;
      st.ctrl  <= fple_pkg::CTRL_RST;
      st.half  <= fple_pkg::BLINK_RST;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs, all straight from flops
  // ---------------------------------------------------------------------------
  assign prdata  = st.rdata;
  assign pready  = st.rdy;
  assign pslverr = st.err;
  assign power_sleep_indicator_green    = st.led[0];
  assign power_sleep_indicator_yellow   = st.led[1];
  assign status_green                   = st.led[2];
  assign status_amber                   = st.led[3];
  assign disk_green                     = st.led[4];
  assign disk_amber                     = st.led[5];
  assign network_one_activity_indicator = st.led[6];
  assign network_two_activity_indicator = st.led[7];
  assign ident_blue                     = st.led[8];
  assign jack_a_speed_green             = st.led[9];
  assign jack_a_link_yellow             = st.led[10];
  assign jack_b_speed_green             = st.led[11];
  assign jack_b_speed_yellow            = st.led[12];
  assign jack_b_link_green              = st.led[13];

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_PWR_ON: assert property (
    pwr_state == fple_pkg::FPLE_PWR_ON |=> power_sleep_indicator_green
      && !power_sleep_indicator_yellow) else $error("power led not green");
  AST_PWR_OFF: assert property (
    pwr_state == fple_pkg::FPLE_PWR_OFF |=> !power_sleep_indicator_green
      && !power_sleep_indicator_yellow) else $error("power led lit when off");
  AST_ST_READY: assert property (
    en && sys_ready && !crit_alarm && !noncrit_alarm && !degraded
      |=> status_green && !status_amber) else $error("status not green");
  AST_ST_CRIT: assert property (
    en && sys_ready && crit_alarm |=> status_amber && !status_green)
    else $error("status not amber");
  AST_ST_DARK: assert property (
    !sys_ready |=> !status_green && !status_amber)
    else $error("status lit when not ready");
  AST_DISK_FAULT: assert property (
    en && disk_fault |=> disk_amber && !disk_green)
    else $error("disk fault not amber");
  AST_NET_LINK: assert property (
    en && net_link[0] && !net_act[0] |=> network_one_activity_indicator)
    else $error("link led dark");
  AST_GIG_SPD: assert property (
    en && net_speed_b == fple_pkg::FPLE_SPD_1000 |=> jack_b_speed_yellow
      && !jack_b_speed_green) else $error("gigabit speed colour");
  AST_ID_OFF: assert property (
    !identify |=> !ident_blue) else $error("identify lit");
  AST_APB_RDY: assert property (
    psel && penable && !pready |=> pready) else $error("apb ready late");

endmodule // fple_led_encoder

// File: sim/fple_src_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// system status sources: power, alarms, disks, network, identify
// ---------------------------------------------------------------------------
// levels change only just after a rising edge, as real sources would
module fple_src_model (
  input  wire logic        pclk,
  output logic [19:0]      cond
);
  // packed condition vector, see bench for bit layout
  initial cond = 20'h00000;

  // apply a new set of conditions on the next edge
  task automatic set(input logic [19:0] v);
    @(posedge pclk);
    cond <= v;
  endtask
endmodule // fple_src_model

// File: sim/fple_led_encoder_tb.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// bench for the front panel indicator encoder
// ---------------------------------------------------------------------------
// cond bits: 1:0 pwr, 2 rdy, 3 crit, 4 noncrit, 5 degr, 9:6 disks,
// 10 fault, 12:11 link, 14:13 act, 16:15 speed a, 18:17 speed b, 19 ident
module fple_led_encoder_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [19:0] cond;
  logic [13:0] led;       // led outputs in port order
  int          error_cnt, checks;
  int          cnt [14];  // lit cycles per led in a window

  fple_src_model u_src (.pclk(pclk), .cond(cond));

  fple_led_encoder #(.NDISK(4)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pwr_state(cond[1:0]),
    .sys_ready(cond[2]), .crit_alarm(cond[3]), .noncrit_alarm(cond[4]),
    .degraded(cond[5]), .disk_access(cond[9:6]), .disk_fault(cond[10]),
    .net_link(cond[12:11]), .net_act(cond[14:13]),
    .net_speed_a(cond[16:15]), .net_speed_b(cond[18:17]),
    .identify(cond[19]), .power_sleep_indicator_green(led[0]),
    .power_sleep_indicator_yellow(led[1]), .status_green(led[2]),
    .status_amber(led[3]), .disk_green(led[4]), .disk_amber(led[5]),
    .network_one_activity_indicator(led[6]),
    .network_two_activity_indicator(led[7]), .ident_blue(led[8]),
    .jack_a_speed_green(led[9]), .jack_a_link_yellow(led[10]),
    .jack_b_speed_green(led[11]), .jack_b_speed_yellow(led[12]),
    .jack_b_link_green(led[13]));

  // ---------------------------------------------------------------------------
  // clock, reset and watchdog
  // ---------------------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // generous bound: the whole run needs some 600 cycles
  initial begin
    #2000000;
    error_cnt++;
    end_sim();
  end

  // ---------------------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask

  // one apb transfer; waits for pready without assuming a latency
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // request stands until the edge at which pready is sampled high
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    chk(n < 50, "no pready");
    // answer taken at that same edge, then the request is released
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  // apply conditions, then count lit cycles over a 24 cycle window
  task automatic look(input logic [19:0] v);
    u_src.set(v);
    repeat (3) @(posedge pclk);
    foreach (cnt[i]) cnt[i] = 0;
    repeat (24) begin
      @(negedge pclk);
      foreach (cnt[i]) cnt[i] += (led[i] === 1'b1);
    end
  endtask

  // e: 0 dark, 1 steady, 2 blinking (blink half period is 4)
  task automatic m(input int i, input int e);
    chk(e == 0 ? cnt[i] == 0 : e == 1 ? cnt[i] == 24 :
        cnt[i] > 0 && cnt[i] < 24, $sformatf("led %0d mode", i));
  endtask

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic t_regs;
    apb(1'b0, fple_pkg::OFS_CTRL, 32'h0);
    chk(rd === 32'h2 && er === 1'b0, "ctrl reset");
    apb(1'b0, fple_pkg::OFS_BLINK, 32'h0);
    chk(rd === 32'h000F4240, "blink reset");
    apb(1'b1, fple_pkg::OFS_BLINK, 32'h4);
    apb(1'b0, fple_pkg::OFS_BLINK, 32'h0);
    chk(rd === 32'h4, "blink write");
    apb(1'b0, 12'h010, 32'h0);
    chk(er === 1'b1 && rd === 32'h0, "unmapped");
  endtask

  task automatic t_power;
    look(20'h1); m(0, 1); m(1, 0);
    look(20'h2); m(0, 2); m(1, 0);
    look(20'h0); m(0, 0); m(1, 0);
    apb(1'b1, fple_pkg::OFS_CTRL, 32'h3);
    look(20'h2); m(0, 0); m(1, 1);
    look(20'h3); m(0, 0); m(1, 0);
    apb(1'b1, fple_pkg::OFS_CTRL, 32'h2);
  endtask

  // ready, degraded, noncritical, critical, not ready; alarms pile up
  task automatic t_status;
    logic [19:0] tv [5] = '{20'h05, 20'h25, 20'h35, 20'h3D, 20'h39};
    int          g [5]  = '{1, 2, 0, 0, 0};
    int          a [5]  = '{0, 0, 2, 1, 0};
    for (int k = 0; k < 5; k++) begin
      look(tv[k]); m(2, g[k]); m(3, a[k]);
      apb(1'b0, fple_pkg::OFS_COND, 32'h0);
      chk(rd === 32'(4 - k), "severity");
    end
  endtask

  task automatic t_disk;
    look(20'h205); m(4, 2); m(5, 0);
    look(20'h045); m(4, 2);
    look(20'h645); m(4, 0); m(5, 1);
    look(20'h005); m(4, 0); m(5, 0);
  endtask

  task automatic t_net;
    look(20'h49805); m(6, 1); m(7, 1); m(9, 1); m(10, 1);
    m(11, 0); m(12, 1); m(13, 1);
    look(20'h4F805); m(6, 2); m(7, 2); m(10, 2); m(13, 2);
    look(20'h20005); m(6, 0); m(7, 0); m(9, 0); m(10, 0);
    m(11, 1); m(12, 0); m(13, 0);
  endtask

  task automatic t_ident;
    look(20'h80005); m(8, 2);
    look(20'h00005); m(8, 0);
  endtask

  // ---------------------------------------------------------------------------
  // verdict and main sequence
  // ---------------------------------------------------------------------------
  task automatic end_sim;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; error_cnt = 0; checks = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_power();
    t_status();
    t_disk();
    t_net();
    t_ident();
    end_sim();
  end
endmodule // fple_led_encoder_tb
